/* File: rtl/tar_fall_detect.sv */
// Falling-edge detector for a pin that is already synchronous to the clock.
module tar_fall_detect
	import tar_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pin,
	output logic fall
);

	tar_edge_state_t s_q;
	tar_edge_state_t s_d;

	// The previous level is remembered every cycle.
	always_comb begin
		s_d = s_q;
		s_d.prev = pin;
	end

	// State register; the pin is assumed idle high out of reset.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q.prev <= PIN_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// One-cycle pulse while the pin is low after being high.
	assign fall = s_q.prev & ~pin;

endmodule

/* File: rtl/tar_pkg.sv */
// Package of register indices, field positions, reset values and state types for the timer block.
package tar_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry: byte address is four times the register index.
	localparam int ADR_W = 10;
	localparam int IDX_W = 8;
	localparam logic [23:0] PAD_ZERO = 24'h000000;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices.
	localparam logic [IDX_W-1:0] IDX_TIMER_CTRL = 8'h88;
	localparam logic [IDX_W-1:0] IDX_T0_COUNT = 8'h8A;
	localparam logic [IDX_W-1:0] IDX_T1_COUNT = 8'h8B;
	localparam logic [IDX_W-1:0] IDX_T0_RELOAD = 8'h8C;
	localparam logic [IDX_W-1:0] IDX_T1_RELOAD = 8'h8D;
	localparam logic [IDX_W-1:0] IDX_T2_CONTROL = 8'hC8;
	localparam logic [IDX_W-1:0] IDX_CAP_LOW = 8'hCA;
	localparam logic [IDX_W-1:0] IDX_CAP_HIGH = 8'hCB;
	localparam logic [IDX_W-1:0] IDX_WIDE_LOW = 8'hCC;
	localparam logic [IDX_W-1:0] IDX_WIDE_HIGH = 8'hCD;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hE0;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 8'hE1;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'hE2;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of timer_control_reg.
	localparam int TC_RUN0 = 4;
	localparam int TC_FLAG0 = 5;
	localparam int TC_RUN1 = 6;
	localparam int TC_FLAG1 = 7;

	// Field positions of timer2_control.
	localparam int T2_CPRL = 0;
	localparam int T2_CT = 1;
	localparam int T2_RUN = 2;
	localparam int T2_EXEN = 3;
	localparam int T2_UART_TX_CLOCK_SELECT = 4;
	localparam int T2_RCLK = 5;
	localparam int T2_EXF = 6;
	localparam int T2_TF = 7;

	// Interrupt status, clear and enable layout.
	localparam int IRQ_T0 = 0;
	localparam int IRQ_T1 = 1;
	localparam int IRQ_TF2 = 2;
	localparam int IRQ_WIDE_TIMER_EXT_EVENT_FLAG = 3;
	localparam int IRQ_W = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and count limits.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WIDE = 16'h0000;
	localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [7:0] COUNT_MAX8 = 8'hFF;
	localparam logic [15:0] COUNT_MAX16 = 16'hFFFF;
	localparam logic [7:0] STEP8 = 8'h01;
	localparam logic [15:0] STEP16 = 16'h0001;
	localparam logic PIN_IDLE = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// State types.
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] reload;
	} tar_t8_state_t;

	typedef struct packed {
		logic prev;
	} tar_edge_state_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] timer_control_reg;
		logic [7:0] timer2_control;
		logic [7:0] cap_l;
		logic [7:0] cap_h;
		logic [15:0] wide;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
	} tar_top_state_t;

endpackage

/* File: rtl/tar_timer8.sv */
// Eight-bit timer with automatic reload of its start value.
module tar_timer8
	import tar_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	tar_tmr_if.tmr tmr
);

	tar_t8_state_t s_q;
	tar_t8_state_t s_d;
	logic rollover;

	// Rollover happens on the tick that would take the count past all ones.
	assign rollover = tmr.run & (s_q.count == COUNT_MAX8);

	// Count, reload on rollover, and software loads last so they win.
	always_comb begin
		s_d = s_q;
		if (tmr.run) begin
			s_d.count = s_q.count + STEP8;
		end
		if (rollover) begin
			s_d.count = s_q.reload;
		end
		if (tmr.wr_count) begin
			s_d.count = tmr.wdata;
		end
		if (tmr.wr_reload) begin
			s_d.reload = tmr.wdata;
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q <= {RST_BYTE, RST_BYTE};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come from the state flops, the overflow is a pulse.
	assign tmr.count = s_q.count;
	assign tmr.reload = s_q.reload;
	assign tmr.ovf = rollover;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the reload behaviour.
	a_reload_on_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		(rollover && !tmr.wr_count) |=> (s_q.count == $past(s_q.reload)))
		else $error("count not reloaded after rollover");
	a_reload_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!tmr.wr_reload) |=> (s_q.reload == $past(s_q.reload)))
		else $error("reload byte changed without a write");

endmodule

/* File: rtl/tar_timer_top.sv */
// Timer block: two eight-bit auto-reload timers, one sixteen-bit timer and a Wishbone register file.
//
// Added by the designer: the Wishbone slave port.
module tar_timer_top
	import tar_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_count_pin,
	input wire logic ext_trigger_pin,
	output logic irq,
	output logic uart_tx_clk_tick,
	output logic uart_rx_clk_tick
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	tar_top_state_t s_q;
	tar_top_state_t s_d;
	tar_tmr_if t8_if[2] ();
	logic [IDX_W-1:0] adr_idx;
	logic wr_go;
	logic cnt_fall;
	logic trig_fall;
	logic t0_ovf;
	logic t1_ovf;
	logic baud_mode;
	logic capture_mode;
	logic wide_tick;
	logic wide_ovf;
	logic trig;
	logic [IRQ_W-1:0] irq_events;

	// True when the write that completes in this cycle targets the given index.
	function automatic logic wr_hit(input logic go, input logic [IDX_W-1:0] adr, input logic [IDX_W-1:0] idx);
		wr_hit = go & (adr == idx);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode: a write takes effect on the edge where ack is high, low byte lane only.
	assign adr_idx = wb_adr_i[ADR_W-1:2];
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack & wb_sel_i[0];

	////////////////////////////////////////////////////////////////////////////////
	// Two eight-bit timers, identical apart from their control bits and indices.
	generate
		for (genvar gi = 0; gi < 2; gi++) begin : g_t8
			localparam logic [IDX_W-1:0] CNT_IDX = (gi == 0) ? IDX_T0_COUNT : IDX_T1_COUNT;
			localparam logic [IDX_W-1:0] RLD_IDX = (gi == 0) ? IDX_T0_RELOAD : IDX_T1_RELOAD;
			localparam int RUN_BIT = (gi == 0) ? TC_RUN0 : TC_RUN1;

			// Run bit and software loads for this timer.
			assign t8_if[gi].run = s_q.timer_control_reg[RUN_BIT];
			assign t8_if[gi].wr_count = wr_hit(wr_go, adr_idx, CNT_IDX);
			assign t8_if[gi].wr_reload = wr_hit(wr_go, adr_idx, RLD_IDX);
			assign t8_if[gi].wdata = wb_dat_i[7:0];

			tar_timer8 u_timer8 (
				.clk_sys(clk_sys),
				.resetn(resetn),
				.tmr(t8_if[gi])
			);
		end
	endgenerate

	assign t0_ovf = t8_if[0].ovf;
	assign t1_ovf = t8_if[1].ovf;

	////////////////////////////////////////////////////////////////////////////////
	// Edge detectors on the count pin and on the trigger pin.
	tar_fall_detect u_cnt_edge (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pin(ext_count_pin),
		.fall(cnt_fall)
	);

	tar_fall_detect u_trig_edge (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pin(ext_trigger_pin),
		.fall(trig_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Wide timer mode decode; baud mode overrides the capture select.
	assign baud_mode = s_q.timer2_control[T2_RCLK] | s_q.timer2_control[T2_UART_TX_CLOCK_SELECT];
	assign capture_mode = s_q.timer2_control[T2_CPRL] & ~baud_mode;
	assign wide_tick = s_q.timer2_control[T2_RUN] & (s_q.timer2_control[T2_CT] ? cnt_fall : 1'b1);
	assign wide_ovf = wide_tick & (s_q.wide == COUNT_MAX16);
	assign trig = s_q.timer2_control[T2_EXEN] & trig_fall & ~baud_mode;

	// Events that set the sticky interrupt status bits.
	always_comb begin
		irq_events = RST_IRQ;
		irq_events[IRQ_T0] = t0_ovf;
		irq_events[IRQ_T1] = t1_ovf;
		irq_events[IRQ_TF2] = wide_ovf & ~baud_mode;
		irq_events[IRQ_WIDE_TIMER_EXT_EVENT_FLAG] = trig;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state of the register file and the wide timer.
	always_comb begin
		logic [7:0] rd_byte;
		rd_byte = RST_BYTE;
		s_d = s_q;
		// Bus answer one cycle after the request, dropped the cycle after.
		s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
		case (adr_idx)
			IDX_TIMER_CTRL: rd_byte = s_q.timer_control_reg;
			IDX_T0_COUNT: rd_byte = t8_if[0].count;
			IDX_T1_COUNT: rd_byte = t8_if[1].count;
			IDX_T0_RELOAD: rd_byte = t8_if[0].reload;
			IDX_T1_RELOAD: rd_byte = t8_if[1].reload;
			IDX_T2_CONTROL: rd_byte = s_q.timer2_control;
			IDX_CAP_LOW: rd_byte = s_q.cap_l;
			IDX_CAP_HIGH: rd_byte = s_q.cap_h;
			IDX_WIDE_LOW: rd_byte = s_q.wide[7:0];
			IDX_WIDE_HIGH: rd_byte = s_q.wide[15:8];
			IDX_IRQ_STATUS: rd_byte = 8'(s_q.irq_st);
			IDX_IRQ_ENABLE: rd_byte = 8'(s_q.irq_en);
			default: rd_byte = RST_BYTE;
		endcase
		if (s_d.ack) begin
			s_d.rdata = {PAD_ZERO, rd_byte};
		end
		// Control register of the eight-bit timers; hardware sets win over the write.
		if (wr_hit(wr_go, adr_idx, IDX_TIMER_CTRL)) begin
			s_d.timer_control_reg = wb_dat_i[7:0];
		end
		if (t0_ovf) begin
			s_d.timer_control_reg[TC_FLAG0] = 1'b1;
		end
		if (t1_ovf) begin
			s_d.timer_control_reg[TC_FLAG1] = 1'b1;
		end
		// Wide timer control; its flags are set by hardware after the write.
		if (wr_hit(wr_go, adr_idx, IDX_T2_CONTROL)) begin
			s_d.timer2_control = wb_dat_i[7:0];
		end
		if (wide_ovf && !baud_mode) begin
			s_d.timer2_control[T2_TF] = 1'b1;
		end
		if (trig) begin
			s_d.timer2_control[T2_EXF] = 1'b1;
		end
		// Wide count: tick, then reload on overflow or trigger in reload mode.
		if (wide_tick) begin
			s_d.wide = s_q.wide + STEP16;
		end
		if ((wide_ovf || trig) && !capture_mode) begin
			s_d.wide = {s_q.cap_h, s_q.cap_l};
		end
		if (wr_hit(wr_go, adr_idx, IDX_WIDE_LOW)) begin
			s_d.wide[7:0] = wb_dat_i[7:0];
		end
		if (wr_hit(wr_go, adr_idx, IDX_WIDE_HIGH)) begin
			s_d.wide[15:8] = wb_dat_i[7:0];
		end
		// Capture registers; a capture in the same cycle beats a software write.
		if (wr_hit(wr_go, adr_idx, IDX_CAP_LOW)) begin
			s_d.cap_l = wb_dat_i[7:0];
		end
		if (wr_hit(wr_go, adr_idx, IDX_CAP_HIGH)) begin
			s_d.cap_h = wb_dat_i[7:0];
		end
		if (trig && capture_mode) begin
			s_d.cap_l = s_q.wide[7:0];
			s_d.cap_h = s_q.wide[15:8];
		end
		// Interrupt status: write-one-to-clear, new events win over the clear.
		if (wr_hit(wr_go, adr_idx, IDX_IRQ_CLEAR)) begin
			s_d.irq_st = s_q.irq_st & ~wb_dat_i[IRQ_W-1:0];
		end
		s_d.irq_st = s_d.irq_st | irq_events;
		if (wr_hit(wr_go, adr_idx, IDX_IRQ_ENABLE)) begin
			s_d.irq_en = wb_dat_i[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q.ack <= 1'b0;
			s_q.rdata <= RST_WORD;
			s_q.timer_control_reg <= RST_BYTE;
			s_q.timer2_control <= RST_BYTE;
			s_q.cap_l <= RST_BYTE;
			s_q.cap_h <= RST_BYTE;
			s_q.wide <= RST_WIDE;
			s_q.irq_st <= RST_IRQ;
			s_q.irq_en <= RST_IRQ;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	assign irq = |(s_q.irq_st & s_q.irq_en);

	// UART clock ticks come from the wide timer when selected, else from the second timer.
	assign uart_tx_clk_tick = s_q.timer2_control[T2_UART_TX_CLOCK_SELECT] ? wide_ovf : t1_ovf;
	assign uart_rx_clk_tick = s_q.timer2_control[T2_RCLK] ? wide_ovf : t1_ovf;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// Software writes that may legally move guarded state in the same cycle.
	logic wr_timer2_control;
	logic wr_wide;
	logic wr_cap;
	logic wr_clear;
	logic wr_enable;
	assign wr_timer2_control = wr_hit(wr_go, adr_idx, IDX_T2_CONTROL);
	assign wr_wide = wr_hit(wr_go, adr_idx, IDX_WIDE_LOW) | wr_hit(wr_go, adr_idx, IDX_WIDE_HIGH);
	assign wr_cap = wr_hit(wr_go, adr_idx, IDX_CAP_LOW) | wr_hit(wr_go, adr_idx, IDX_CAP_HIGH);
	assign wr_clear = wr_hit(wr_go, adr_idx, IDX_IRQ_CLEAR);
	assign wr_enable = wr_hit(wr_go, adr_idx, IDX_IRQ_ENABLE);

	// Bus answer: one ack per request, in the cycle after the request is seen.
	a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus request not answered in the next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held for more than one cycle");

	// Eight-bit timers: flag on every overflow, interrupt on every enabled overflow, sticky status of the first timer.
	a_t0_flag_set: assert property (t0_ovf |=> s_q.timer_control_reg[TC_FLAG0])
		else $error("first timer flag not set on overflow");
	a_t0_irq_raise: assert property ((t0_ovf && s_q.irq_en[IRQ_T0] && !wr_enable) |=> irq)
		else $error("interrupt not raised on enabled overflow");
	a_status_sticky: assert property ((s_q.irq_st[IRQ_T0] && !wr_clear) |=> s_q.irq_st[IRQ_T0])
		else $error("first timer status dropped without a clear");
	a_t1_flag_set: assert property (t1_ovf |=> s_q.timer_control_reg[TC_FLAG1])
		else $error("second timer flag not set on overflow");
	a_t1_irq_raise: assert property ((t1_ovf && s_q.irq_en[IRQ_T1] && !wr_enable) |=> irq)
		else $error("interrupt not raised on enabled second timer overflow");

	// Wide timer: wrap or reload on overflow, sticky flag, and no flag in baud mode.
	a_wide_wrap_flag: assert property ((wide_ovf && !baud_mode && !wr_wide)
		|=> (s_q.timer2_control[T2_TF]
			&& s_q.wide == ($past(capture_mode) ? RST_WIDE : {$past(s_q.cap_h), $past(s_q.cap_l)})))
		else $error("wide overflow flag not set or count not restarted on wrap");
	a_wide_flag_sticky: assert property ((s_q.timer2_control[T2_TF] && !wr_timer2_control) |=> s_q.timer2_control[T2_TF])
		else $error("wide overflow flag dropped without a write");
	a_wide_irq_status: assert property ((wide_ovf && !baud_mode) |=> s_q.irq_st[IRQ_TF2])
		else $error("wide overflow status not set");
	a_baud_no_flag: assert property ((baud_mode && !wr_timer2_control)
		|=> (s_q.timer2_control[T2_TF] == $past(s_q.timer2_control[T2_TF])))
		else $error("wide overflow flag moved in baud mode");

	// Trigger pin: ignored while disabled or in baud mode, otherwise a capture or a reload plus the event flag.
	a_trig_ignored: assert property ((!s_q.timer2_control[T2_EXEN] && !wr_timer2_control) |=> $stable(s_q.timer2_control[T2_EXF]))
		else $error("trigger flag changed while disabled");
	a_ext_flag_set: assert property (trig |=> s_q.timer2_control[T2_EXF])
		else $error("trigger event flag not set");
	a_trig_status: assert property (trig |=> s_q.irq_st[IRQ_WIDE_TIMER_EXT_EVENT_FLAG])
		else $error("trigger event status not set");
	a_capture_copy: assert property ((trig && capture_mode)
		|=> ({s_q.cap_h, s_q.cap_l} == $past(s_q.wide)))
		else $error("capture did not copy the wide count");
	a_reload_edge: assert property ((trig && !capture_mode && !wr_wide)
		|=> (s_q.wide == {$past(s_q.cap_h), $past(s_q.cap_l)}))
		else $error("wide timer not loaded from capture registers");
	a_cap_hold: assert property ((!capture_mode && !wr_cap) |=> $stable({s_q.cap_h, s_q.cap_l}))
		else $error("reload value changed without a write");
	a_stopped_hold: assert property ((!s_q.timer2_control[T2_RUN] && !trig && !wr_wide) |=> $stable(s_q.wide))
		else $error("wide timer moved while stopped");

	// Baud mode: each routed tick is a wide overflow that reloads from the capture registers.
	a_tx_baud_reload: assert property ((s_q.timer2_control[T2_UART_TX_CLOCK_SELECT] && uart_tx_clk_tick && !wr_wide)
		|=> (s_q.wide == {$past(s_q.cap_h), $past(s_q.cap_l)}))
		else $error("transmit clock tick without a wide reload");
	a_rx_baud_reload: assert property ((s_q.timer2_control[T2_RCLK] && uart_rx_clk_tick && !wr_wide)
		|=> (s_q.wide == {$past(s_q.cap_h), $past(s_q.cap_l)}))
		else $error("receive clock tick without a wide reload");

	c_t0_overflow: cover property (t0_ovf ##1 irq);
	c_t1_overflow: cover property (t1_ovf ##1 irq);
	c_capture: cover property (trig && capture_mode);
	c_reload_edge: cover property (trig && !capture_mode);
	c_baud_tick: cover property (baud_mode && wide_ovf);

endmodule

/* File: rtl/tar_tmr_if.sv */
// Interface between the register side and one eight-bit auto-reload timer.
interface tar_tmr_if;
	logic run;
	logic wr_count;
	logic wr_reload;
	logic [7:0] wdata;
	logic [7:0] count;
	logic [7:0] reload;
	logic ovf;

	// The register side steers, the timer answers.
	modport ctl (output run, output wr_count, output wr_reload, output wdata, input count, input reload, input ovf);
	modport tmr (input run, input wr_count, input wr_reload, input wdata, output count, output reload, output ovf);
endinterface

/* File: tb/tar_pin_model.sv */
// Model of the external pins that feed the wide timer's count and trigger inputs.
module tar_pin_model
	import tar_pkg::*;
(
	input wire logic clk_sys,
	output logic ext_count_pin,
	output logic ext_trigger_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////////////
	// Both pins rest at their pulled-up idle level.
	initial begin
		ext_count_pin = PIN_IDLE;
		ext_trigger_pin = PIN_IDLE;
	end

	// Sends n falling edges; gap sets how many cycles each level is held, so edges come fast or slow.
	task automatic pulse_count(input int n, input int gap);
		repeat (n) begin
			@(posedge clk_sys);
			ext_count_pin <= 1'b0;
			repeat (gap) @(posedge clk_sys);
			ext_count_pin <= PIN_IDLE;
			repeat (gap) @(posedge clk_sys);
		end
	endtask

	// Sends one falling edge on the trigger pin and returns it to idle.
	task automatic pulse_trigger();
		@(posedge clk_sys);
		ext_trigger_pin <= 1'b0;
		repeat (2) @(posedge clk_sys);
		ext_trigger_pin <= PIN_IDLE;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule

/* File: tb/timer_autoreload_capture_tb_top.sv */
// Self-checking testbench for the timer block with a behavioural model of the wide count.
module timer_autoreload_capture_tb_top
	import tar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic ext_count_pin;
	logic ext_trigger_pin;
	logic irq;
	logic uart_tx_clk_tick;
	logic uart_rx_clk_tick;
	logic [3:0] sel_v = 4'hF;
	logic [31:0] rnd = 32'h0000A97D;
	logic [31:0] q;
	logic [7:0] pat;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	int tx_n = 0;
	int rx_n = 0;
	int tx0;
	int rx0;
	int mdl_wide;
	logic [7:0] idx_tab [14] = '{IDX_TIMER_CTRL, IDX_T0_COUNT, IDX_T1_COUNT, IDX_T0_RELOAD, IDX_T1_RELOAD,
		IDX_T2_CONTROL, IDX_CAP_LOW, IDX_CAP_HIGH, IDX_WIDE_LOW, IDX_WIDE_HIGH, IDX_IRQ_STATUS,
		IDX_IRQ_CLEAR, IDX_IRQ_ENABLE, 8'h00};
	logic [7:0] rw_tab [$] = '{IDX_T0_RELOAD, IDX_T1_RELOAD, IDX_CAP_LOW, IDX_CAP_HIGH};

	always #25 clk_sys = ~clk_sys;

	tar_timer_top dut (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ext_count_pin(ext_count_pin), .ext_trigger_pin(ext_trigger_pin), .irq(irq),
		.uart_tx_clk_tick(uart_tx_clk_tick), .uart_rx_clk_tick(uart_rx_clk_tick));

	tar_pin_model pins (.clk_sys(clk_sys), .ext_count_pin(ext_count_pin), .ext_trigger_pin(ext_trigger_pin));

	////////////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic summarize();
		if (fails == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Counts baud ticks and cuts a hung run short.
	always @(posedge clk_sys) begin
		if (uart_tx_clk_tick === 1'b1) tx_n <= tx_n + 1;
		if (uart_rx_clk_tick === 1'b1) rx_n <= rx_n + 1;
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			summarize();
		end
	end

	// Compares one value and reports a mismatch.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction

	// One classic Wishbone cycle; the request holds until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		rnd = lfsr(rnd);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel_v;
		wb_dat_i <= {rnd[31:8], d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1);
		check("bus answer cycles", 32'(n), 32'h2);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		check($sformatf("register %h", idx), q, {PAD_ZERO, exp});
	endtask

	// Edges on the count pin, mirrored in the model; reload below zero means wrap to zero.
	task automatic count_pin(input int n, input int gap, input int reload);
		pins.pulse_count(n, gap);
		repeat (n) mdl_wide = (mdl_wide == 'hFFFF) ? ((reload < 0) ? 0 : reload) : mdl_wide + 1;
	endtask

	task automatic wr_wide(input logic [15:0] v);
		wr(IDX_WIDE_LOW, v[7:0]);
		wr(IDX_WIDE_HIGH, v[15:8]);
		mdl_wide = v;
	endtask

	task automatic rd_wide();
		rd(IDX_WIDE_LOW, 8'(mdl_wide));
		rd(IDX_WIDE_HIGH, 8'(mdl_wide >> 8));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, registers, eight-bit timers, then the wide timer modes.
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		foreach (idx_tab[i]) rd(idx_tab[i], 8'h00);
		check("irq after reset", {31'h0, irq}, 32'h0);
		sel_v = 4'hE;
		wr(IDX_T0_RELOAD, 8'h5A);
		sel_v = 4'hF;
		rd(IDX_T0_RELOAD, 8'h00);
		wr(IDX_IRQ_STATUS, 8'hFF);
		rd(IDX_IRQ_STATUS, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		foreach (rw_tab[i]) begin
			pat = rnd[7:0] ^ 8'h3C;
			wr(rw_tab[i], pat);
			rd(rw_tab[i], pat);
		end
		for (int t = 0; t < 2; t++) begin
			tx0 = tx_n;
			rx0 = rx_n;
			wr(IDX_IRQ_ENABLE, 8'(1 << t));
			wr(IDX_T0_RELOAD + 8'(t), 8'hF0);
			wr(IDX_T0_COUNT + 8'(t), 8'hFA);
			wr(IDX_TIMER_CTRL, 8'(1 << (TC_RUN0 + 2 * t)));
			repeat (6) @(posedge clk_sys);
			check("irq before overflow", {31'h0, irq}, 32'h0);
			@(posedge clk_sys);
			check("irq at overflow", {31'h0, irq}, 32'h1);
			rd(IDX_TIMER_CTRL, 8'(3 << (TC_RUN0 + 2 * t)));
			wr(IDX_TIMER_CTRL, 8'(1 << (TC_FLAG0 + 2 * t)));
			rd(IDX_T0_COUNT + 8'(t), 8'hF7);
			rd(IDX_T0_RELOAD + 8'(t), 8'hF0);
			rd(IDX_TIMER_CTRL, 8'(1 << (TC_FLAG0 + 2 * t)));
			rd(IDX_IRQ_STATUS, 8'(1 << t));
			check("tx ticks", 32'(tx_n - tx0), 32'(t));
			check("rx ticks", 32'(rx_n - rx0), 32'(t));
			wr(IDX_IRQ_CLEAR, 8'(1 << t));
			wr(IDX_TIMER_CTRL, 8'h00);
			rd(IDX_IRQ_STATUS, 8'h00);
			check("irq after clear", {31'h0, irq}, 32'h0);
		end
		// Capture mode on count pin edges, trigger ignored and then taken.
		wr(IDX_IRQ_ENABLE, 8'h00);
		wr(IDX_CAP_LOW, 8'h00);
		wr(IDX_CAP_HIGH, 8'h00);
		wr_wide(16'h12FD);
		wr(IDX_T2_CONTROL, 8'h07);
		count_pin(2, 1, -1);
		pins.pulse_trigger();
		rd(IDX_CAP_LOW, 8'h00);
		rd(IDX_T2_CONTROL, 8'h07);
		wr(IDX_T2_CONTROL, 8'h0F);
		pins.pulse_trigger();
		rd(IDX_CAP_LOW, 8'(mdl_wide));
		rd(IDX_CAP_HIGH, 8'(mdl_wide >> 8));
		rd(IDX_T2_CONTROL, 8'h4F);
		rd(IDX_IRQ_STATUS, 8'h08);
		check("irq masked", {31'h0, irq}, 32'h0);
		count_pin(1, 3, -1);
		rd_wide();
		wr(IDX_IRQ_ENABLE, 8'h08);
		rd(IDX_IRQ_ENABLE, 8'h08);
		check("irq enabled", {31'h0, irq}, 32'h1);
		wr(IDX_IRQ_CLEAR, 8'h0F);
		rd(IDX_IRQ_STATUS, 8'h00);
		check("irq cleared", {31'h0, irq}, 32'h0);
		// Overflow in capture mode wraps to zero and the flag sticks until written.
		wr(IDX_T2_CONTROL, 8'h07);
		wr_wide(16'hFFFF);
		count_pin(1, 1, -1);
		rd_wide();
		rd(IDX_T2_CONTROL, 8'h87);
		rd(IDX_IRQ_STATUS, 8'h04);
		rd(IDX_T2_CONTROL, 8'h87);
		wr(IDX_T2_CONTROL, 8'h07);
		rd(IDX_T2_CONTROL, 8'h07);
		// Reload mode from the capture registers on overflow and on a trigger.
		wr(IDX_CAP_LOW, 8'h34);
		wr(IDX_CAP_HIGH, 8'h12);
		wr(IDX_T2_CONTROL, 8'h0E);
		wr_wide(16'hFFFF);
		count_pin(1, 1, 'h1234);
		rd_wide();
		count_pin(3, 2, 'h1234);
		pins.pulse_trigger();
		mdl_wide = 'h1234;
		rd_wide();
		rd(IDX_T2_CONTROL, 8'hCE);
		rd(IDX_CAP_LOW, 8'h34);
		// Baud mode forces reload, routes ticks, and ignores triggers and the flag.
		wr(IDX_IRQ_CLEAR, 8'h0F);
		wr(IDX_T2_CONTROL, 8'h1F);
		wr_wide(16'hFFFF);
		tx0 = tx_n;
		rx0 = rx_n;
		count_pin(2, 1, 'h1234);
		pins.pulse_trigger();
		rd_wide();
		rd(IDX_CAP_LOW, 8'h34);
		rd(IDX_T2_CONTROL, 8'h1F);
		rd(IDX_IRQ_STATUS, 8'h00);
		check("baud tx ticks", 32'(tx_n - tx0), 32'h1);
		check("baud rx quiet", 32'(rx_n - rx0), 32'h0);
		wr(IDX_T2_CONTROL, 8'h26);
		wr_wide(16'hFFFF);
		count_pin(1, 1, 'h1234);
		check("baud rx ticks", 32'(rx_n - rx0), 32'h1);
		// Timer function counts every clock while run is set.
		wr(IDX_T2_CONTROL, 8'h00);
		wr_wide(16'h0000);
		wr(IDX_T2_CONTROL, 8'h05);
		wr(IDX_T2_CONTROL, 8'h01);
		mdl_wide = 3;
		rd_wide();
		summarize();
	end
endmodule
